/* File: lsc_params.svh */
// Constants of the special configuration register bank: register
// offsets, reset values, legal ranges, command keys and timing counts.
// Assumes a 40 MHz core clock; included by the package, the register bank and the bench.
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

// Register offsets as seen on the two-wire bus (16-bit register space)
`define LSC_REG_DIST_LO 16'h0000
`define LSC_REG_DIST_HI 16'h0001
`define LSC_REG_STR_LO 16'h0002
`define LSC_REG_STR_HI 16'h0003
`define LSC_REG_ADDR_SET 16'h0026
`define LSC_REG_TRIG_MODE 16'h0027
`define LSC_REG_RESTORE 16'h0070
`define LSC_REG_SHOT 16'h0100

// Reset values and legal ranges
`define LSC_ADDR_RESET 8'h10
`define LSC_ADDR_MIN 8'h10
`define LSC_ADDR_MAX 8'h78
`define LSC_MODE_TIMER 8'h00
`define LSC_MODE_EXT 8'h01

// Command keys
`define LSC_RESTORE_KEY 8'h02
`define LSC_SHOT_KEY 8'h01
`define LSC_SOFTRST_KEY 8'h06

// Weak-signal handling
`define LSC_WEAK_CODE 16'hFFFF
`define LSC_WEAK_LIMIT 16'h0014

// Timing: clock period and internal trigger period, both in ns
`define LSC_CLK_PERIOD_NS 25
`define LSC_TICK_PERIOD_NS 10000000
`define LSC_TICK_CYCLES (`LSC_TICK_PERIOD_NS / `LSC_CLK_PERIOD_NS)

`endif

/* File: lsc_pkg.sv */
// Types shared by the register bank and its two-wire front end.
// Assumes lsc_params.svh sits in the include path.
`include "lsc_params.svh"

package lsc_pkg;

    // Transaction tracker, one-hot
    typedef enum logic [6:0]
    {
        LSC_IDLE = 7'h01,
        LSC_DEVADR = 7'h02,
        LSC_REGHI = 7'h04,
        LSC_REGLO = 7'h08,
        LSC_WDATA = 7'h10,
        LSC_RDATA = 7'h20,
        LSC_SKIP = 7'h40
    } lsc_bus_state_t;

    // State of the bit-level front end
    typedef struct packed
    {
        logic sclD;
        logic sdaD;
        logic active;
        logic inAck;
        logic sending;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] rxByte;
        logic rxValid;
        logic startSeen;
        logic stopSeen;
        logic txDone;
        logic sdaOe;
    } lsc_link_t;

    // State of the register bank
    typedef struct packed
    {
        lsc_bus_state_t busState;
        logic [15:0] ptr;
        logic [7:0] regHi;
        logic [7:0] addrSetting;
        logic [7:0] modeSetting;
        logic [7:0] activeAddr;
        logic [7:0] activeMode;
        logic readMode;
        logic ackOut;
        logic [7:0] txByte;
        logic [31:0] tickCnt;
        logic [15:0] distance;
        logic [15:0] strength;
        logic distValid;
        logic measStart;
        logic restoreDefaults;
        logic sdaLevel;
    } lsc_core_t;

endpackage : lsc_pkg

/* File: lsc_i2c_link.sv */
// Bit-level two-wire slave front end: start/stop detection, byte
// receive, acknowledge drive, byte transmit with master ack sampling.
// Assumes SCL and SDA are already synchronous to core_clk; no stretching.
module lsc_i2c_link
    import lsc_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOe,
    // Byte side
    input wire logic ackIn,
    input wire logic sendNext,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte,
    output logic rxValid,
    output logic startSeen,
    output logic stopSeen,
    output logic txDone
);

    lsc_link_t st; // Registered state
    lsc_link_t next_st; // Next state
    logic sclRise; // SCL edge terms
    logic sclFall;
    logic startCond; // SDA falls while SCL high
    logic stopCond; // SDA rises while SCL high

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_st = st;
        next_st.sclD = sclIn;
        next_st.sdaD = sdaIn;
        next_st.rxValid = 1'b0;
        next_st.startSeen = 1'b0;
        next_st.stopSeen = 1'b0;
        next_st.txDone = 1'b0;
        sclRise = sclIn & ~st.sclD;
        sclFall = ~sclIn & st.sclD;
        startCond = sclIn & st.sclD & st.sdaD & ~sdaIn;
        stopCond = sclIn & st.sclD & ~st.sdaD & sdaIn;
        if (startCond)
        begin
            // Start or repeated start restarts byte framing
            next_st.active = 1'b1;
            next_st.bitCnt = 4'h0;
            next_st.inAck = 1'b0;
            next_st.sending = 1'b0;
            next_st.sdaOe = 1'b0;
            next_st.startSeen = 1'b1;
        end
        else if (stopCond)
        begin
            next_st.active = 1'b0;
            next_st.sdaOe = 1'b0;
            next_st.stopSeen = 1'b1;
        end
        else if (st.active && sclRise)
        begin
            if (!st.inAck)
            begin
                // Data bit: high byte bit first
                next_st.bitCnt = st.bitCnt + 4'h1;
                if (!st.sending)
                begin
                    next_st.shift = {st.shift[6:0], sdaIn};
                    if (st.bitCnt == 4'h7)
                    begin
                        next_st.rxByte = {st.shift[6:0], sdaIn};
                        next_st.rxValid = 1'b1;
                    end
                end
            end
            else if (st.sending && sdaIn)
            begin
                // Master not-acknowledge ends the read; wait for stop
                next_st.active = 1'b0;
            end
        end
        else if (st.active && sclFall)
        begin
            if (!st.inAck && st.bitCnt == 4'h8)
            begin
                // Enter ack slot: drive ack on receive, release on send
                next_st.inAck = 1'b1;
                next_st.bitCnt = 4'h0;
                next_st.sdaOe = st.sending ? 1'b0 : ackIn;
                next_st.txDone = st.sending;
                if (!st.sending && !ackIn)
                begin
                    next_st.active = 1'b0;
                end
            end
            else if (st.inAck)
            begin
                // Leave ack slot; a read keeps sending
                next_st.inAck = 1'b0;
                next_st.sending = sendNext;
                next_st.shift = txByte;
                next_st.sdaOe = sendNext & ~txByte[7];
            end
            else if (st.sending)
            begin
                next_st.shift = {st.shift[6:0], 1'b0};
                next_st.sdaOe = ~st.shift[6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register, frozen while ce is low
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{sclD: 1'b1, sdaD: 1'b1, default: '0};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register
    assign sdaOe = st.sdaOe;
    assign rxByte = st.rxByte;
    assign rxValid = st.rxValid;
    assign startSeen = st.startSeen;
    assign stopSeen = st.stopSeen;
    assign txDone = st.txDone;

endmodule : lsc_i2c_link

/* File: lsc_special_regs.sv */
// Special configuration register bank of the ranging module, reached by
// an external two-wire master with 16-bit register addresses.
// Assumes synchronous SCL/SDA samples and a measurement engine that
// answers measStart with one measDone pulse carrying distance/strength.
//
// Function
// R01 - New address and mode apply after reset only
// R02 - Address resets 0x10, accepts 0x10 to 0x78
// R03 - Mode register: 0x00 timer, 0x01 external
// R04 - Timer mode measures once every 10 ms
// R05 - External mode: each 0x01 write, one measurement
// R06 - Host keeps commands at or below 100 Hz
// R07 - 0x02 to restore register restores defaults
// R08 - Weak signal reports 0xFFFF instead of distance
// R09 - Register address sent high byte first
// R10 - Burst bytes go to consecutive registers
// R11 - Single data byte 0x06 resets the device
`include "lsc_params.svh"

module lsc_special_regs
    import lsc_pkg::*;
#(
    parameter int TICK_CYCLES = `LSC_TICK_CYCLES,
    parameter logic [15:0] WEAK_LIMIT = `LSC_WEAK_LIMIT
)
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Two-wire bus pins (open drain)
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Measurement engine
    input wire logic measDone,
    input wire logic [15:0] measDist,
    input wire logic [15:0] measStrength,
    output logic measStart,
    // Results and commands to the rest of the device
    output logic [15:0] distOut,
    output logic distValid,
    output logic restoreDefaults
);

    lsc_core_t st; // Registered state
    lsc_core_t next_st; // Next state
    logic [7:0] rxByte; // Front-end byte interface
    logic rxValid;
    logic startSeen;
    logic stopSeen;
    logic txDone;
    logic wrStrobe; // Data byte lands at st.ptr
    logic softGo; // Reset sequence recognised
    logic extCmd; // Accepted single-shot command
    logic restoreCmd; // Accepted restore command

    ////////////////////////////////////////////////////////////////////
    // Bit-level front end
    lsc_i2c_link lsc_i2c_link_i
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .ackIn(next_st.ackOut),
        .sendNext(st.readMode),
        .txByte(st.txByte),
        .rxByte(rxByte),
        .rxValid(rxValid),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .txDone(txDone)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_st = st;
        next_st.measStart = 1'b0;
        next_st.restoreDefaults = 1'b0;
        next_st.distValid = 1'b0;
        wrStrobe = 1'b0;
        softGo = 1'b0;
        extCmd = 1'b0;
        restoreCmd = 1'b0;

        // Internal trigger timer runs only in the active timer mode
        if (st.activeMode == `LSC_MODE_TIMER)
        begin
            if (st.tickCnt == 32'(TICK_CYCLES - 1)) // see R04
            begin
                next_st.tickCnt = 32'h0;
                next_st.measStart = 1'b1;
            end
            else
            begin
                next_st.tickCnt = st.tickCnt + 32'h1;
            end
        end
        else
        begin
            next_st.tickCnt = 32'h0;
        end

        // Latch each result; weak returns are flagged, not reported
        if (measDone)
        begin
            next_st.distance = (measStrength < WEAK_LIMIT) ?
                `LSC_WEAK_CODE : measDist; // see R08
            next_st.strength = measStrength;
            next_st.distValid = 1'b1;
        end

        // Transaction tracking
        if (startSeen)
        begin
            next_st.busState = LSC_DEVADR;
            next_st.readMode = 1'b0;
            next_st.ackOut = 1'b0;
        end
        else if (stopSeen)
        begin
            // One byte 0x06 after the address and nothing more: reset request
            if (st.busState == LSC_REGLO &&
                st.regHi == `LSC_SOFTRST_KEY)
            begin
                softGo = 1'b1; // see R11
            end
            next_st.busState = LSC_IDLE;
            next_st.readMode = 1'b0;
            next_st.ackOut = 1'b0;
        end
        else if (rxValid)
        begin
            case (st.busState)
                LSC_DEVADR:
                begin
                    // Only the address in force answers, not the stored one
                    if (rxByte[7:1] == st.activeAddr[6:0]) // see R01
                    begin
                        next_st.ackOut = 1'b1;
                        next_st.readMode = rxByte[0];
                        next_st.busState = rxByte[0] ? LSC_RDATA : LSC_REGHI;
                    end
                    else
                    begin
                        next_st.ackOut = 1'b0;
                        next_st.busState = LSC_SKIP;
                    end
                end
                LSC_REGHI:
                begin
                    next_st.regHi = rxByte; // see R09
                    next_st.busState = LSC_REGLO;
                end
                LSC_REGLO:
                begin
                    next_st.ptr = {st.regHi, rxByte}; // see R09
                    next_st.busState = LSC_WDATA;
                end
                LSC_WDATA:
                begin
                    wrStrobe = 1'b1;
                    next_st.ptr = st.ptr + 16'h0001; // see R10
                end
                default:
                begin
                    next_st.busState = st.busState;
                end
            endcase
        end
        else if (txDone && st.busState == LSC_RDATA)
        begin
            next_st.ptr = st.ptr + 16'h0001; // see R10
        end

        // Register writes; out-of-range values are ignored
        if (wrStrobe)
        begin
            case (st.ptr)
                `LSC_REG_ADDR_SET:
                begin
                    if (rxByte >= `LSC_ADDR_MIN && rxByte <= `LSC_ADDR_MAX)
                    begin
                        next_st.addrSetting = rxByte; // see R02
                    end
                end
                `LSC_REG_TRIG_MODE:
                begin
                    if (rxByte == `LSC_MODE_TIMER || rxByte == `LSC_MODE_EXT)
                    begin
                        next_st.modeSetting = rxByte; // see R03
                    end
                end
                `LSC_REG_RESTORE:
                begin
                    // Address and mode are untouched by a restore
                    if (rxByte == `LSC_RESTORE_KEY)
                    begin
                        restoreCmd = 1'b1;
                        next_st.restoreDefaults = 1'b1; // see R07
                    end
                end
                `LSC_REG_SHOT:
                begin
                    // Host pacing is trusted, so no rate limiter here
                    if (rxByte == `LSC_SHOT_KEY &&
                        st.activeMode == `LSC_MODE_EXT) // see R06
                    begin
                        extCmd = 1'b1;
                        next_st.measStart = 1'b1; // see R05
                    end
                end
                default:
                begin
                    next_st.ptr = next_st.ptr;
                end
            endcase
        end

        // Reset sequence: stored settings come into force now
        if (softGo)
        begin
            next_st.activeAddr = st.addrSetting; // see R01
            next_st.activeMode = st.modeSetting; // see R01
            next_st.tickCnt = 32'h0;
        end

        // Read data for the next byte, registered ahead of its use
        case (next_st.ptr)
            `LSC_REG_DIST_LO: next_st.txByte = next_st.distance[7:0];
            `LSC_REG_DIST_HI: next_st.txByte = next_st.distance[15:8];
            `LSC_REG_STR_LO: next_st.txByte = next_st.strength[7:0];
            `LSC_REG_STR_HI: next_st.txByte = next_st.strength[15:8];
            `LSC_REG_ADDR_SET: next_st.txByte = next_st.addrSetting;
            `LSC_REG_TRIG_MODE: next_st.txByte = next_st.modeSetting;
            default: next_st.txByte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register; async reset loads constants only
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{busState: LSC_IDLE,
                    addrSetting: `LSC_ADDR_RESET, // see R02
                    modeSetting: `LSC_MODE_TIMER, // see R03
                    activeAddr: `LSC_ADDR_RESET,
                    activeMode: `LSC_MODE_TIMER,
                    default: '0};
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign sdaOut = st.sdaLevel;
    assign measStart = st.measStart;
    assign distOut = st.distance;
    assign distValid = st.distValid;
    assign restoreDefaults = st.restoreDefaults;

    ////////////////////////////////////////////////////////////////////
    // Checks
    addr_hold_a: assert property ( // see R01
        @(posedge core_clk) disable iff (!resetn)
        (st.activeAddr != $past(st.activeAddr)) |-> $past(softGo))
        else $error("slave address changed without reset sequence");

    addr_range_a: assert property ( // see R02
        @(posedge core_clk) disable iff (!resetn)
        st.addrSetting >= `LSC_ADDR_MIN && st.addrSetting <= `LSC_ADDR_MAX)
        else $error("stored slave address out of range");

    mode_legal_a: assert property ( // see R03
        @(posedge core_clk) disable iff (!resetn)
        st.modeSetting <= `LSC_MODE_EXT && st.activeMode <= `LSC_MODE_EXT)
        else $error("trigger mode holds an illegal value");

    tick_period_a: assert property ( // see R04
        @(posedge core_clk) disable iff (!resetn)
        (ce && !softGo && st.activeMode == `LSC_MODE_TIMER &&
         st.tickCnt == 32'(TICK_CYCLES - 1))
        |=> (st.measStart && st.tickCnt == 32'h0))
        else $error("timer tick did not start a measurement");

    ext_shot_a: assert property ( // see R05
        @(posedge core_clk) disable iff (!resetn)
        (ce && st.activeMode == `LSC_MODE_EXT && !st.measStart)
        |=> (st.measStart == $past(extCmd)))
        else $error("external start does not match accepted command");

    restore_cmd_a: assert property ( // see R07
        @(posedge core_clk) disable iff (!resetn)
        (ce && restoreCmd)
        |=> (st.restoreDefaults && $stable(st.addrSetting) &&
             $stable(st.modeSetting)))
        else $error("restore pulse missing or settings disturbed");

    weak_code_a: assert property ( // see R08
        @(posedge core_clk) disable iff (!resetn)
        (ce && measDone && measStrength < WEAK_LIMIT)
        |=> (st.distValid && st.distance == `LSC_WEAK_CODE))
        else $error("weak return not reported as 0xFFFF");

    ptr_step_a: assert property ( // see R10
        @(posedge core_clk) disable iff (!resetn)
        (ce && wrStrobe) |=> (st.ptr == $past(st.ptr) + 16'h0001))
        else $error("burst pointer did not advance by one");

    soft_apply_a: assert property ( // see R11
        @(posedge core_clk) disable iff (!resetn)
        (ce && softGo)
        |=> (st.activeAddr == $past(st.addrSetting) &&
             st.activeMode == $past(st.modeSetting)))
        else $error("reset sequence did not apply stored settings");

endmodule : lsc_special_regs

/* File: lsc_host_model.sv */
// Behavioural two-wire master that stands in for the host controller.
// Assumes an open-drain SDA with pull-up resolved by the bench.
module lsc_host_model
(
    // Clock
    input wire logic core_clk,
    // Bus lines
    input wire logic sdaIn,
    output logic scl,
    output logic sdaOe
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Lines start idle; a released SDA reads high through the pull-up
    initial
    begin
        scl = 1'b1;
        sdaOe = 1'b0;
    end

    // All line changes happen on falling core clock edges
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // One SCL pulse; SDA sampled late in the high phase for margin
    task automatic pulse(output logic bitIn);
        tick(3);
        scl = 1'b1;
        tick(5);
        bitIn = sdaIn;
        scl = 1'b0;
        tick(2);
    endtask : pulse

    // Start, also used as repeated start from SCL low
    task automatic start();
        sdaOe = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(5);
        sdaOe = 1'b1;
        tick(5);
        scl = 1'b0;
        tick(2);
    endtask : start

    // Stop: SDA rises while SCL is high
    task automatic stop();
        sdaOe = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(5);
        sdaOe = 1'b0;
        tick(5);
    endtask : stop

    // Send a byte MSB first, report whether the slave pulled ack low
    task automatic putByte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
        begin
            sdaOe = ~b[i];
            pulse(a);
        end
        sdaOe = 1'b0;
        pulse(a);
        ack = (a === 1'b0);
    endtask : putByte

    // Receive a byte, then ack or refuse it
    task automatic getByte(input logic nack, output logic [7:0] b);
        logic a;
        sdaOe = 1'b0;
        for (int i = 7; i >= 0; i--)
            pulse(b[i]);
        sdaOe = ~nack;
        pulse(a);
        sdaOe = 1'b0;
    endtask : getByte

    // Address phase: device, then register address high byte first
    task automatic regAddr(input logic [6:0] dev, input logic [15:0] adr,
        output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start();
        putByte({dev, 1'b0}, a0);
        putByte(adr[15:8], a1);
        putByte(adr[7:0], a2);
        ok = a0 & a1 & a2;
    endtask : regAddr

    // Write one or two bytes; the second lands at the next register
    task automatic regWrite(input logic [6:0] dev, input logic [15:0] adr,
        input logic [7:0] d0, input logic [7:0] d1, input int n,
        output logic ok);
        logic a0;
        logic a1;
        logic a2;
        regAddr(dev, adr, a0);
        putByte(d0, a1);
        a2 = 1'b1;
        if (n > 1)
            putByte(d1, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : regWrite

    // Two-byte read through a repeated start; last byte refused
    task automatic regRead(input logic [6:0] dev, input logic [15:0] adr,
        output logic [7:0] b0, output logic [7:0] b1, output logic ok);
        logic a0;
        logic a1;
        regAddr(dev, adr, a0);
        start();
        putByte({dev, 1'b1}, a1);
        getByte(1'b0, b0);
        getByte(1'b1, b1);
        stop();
        ok = a0 & a1;
    endtask : regRead

    // Reset sequence: one data byte 0x06 framed by start and stop
    task automatic resetSeq(input logic [6:0] dev);
        logic a;
        start();
        putByte({dev, 1'b0}, a);
        putByte(8'h06, a);
        stop();
    endtask : resetSeq
endmodule : lsc_host_model

/* File: test_lidar_special_config_regs.sv */
// Self-checking bench of the special configuration register bank.
// Assumes lsc_host_model as bus master; the bench plays the engine.
`include "lsc_params.svh"

module test_lidar_special_config_regs
    import lsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICKS = 20; // Short timer period
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic hostOe;
    logic dutOe;
    logic sdaOut;
    wire logic sda;
    logic measDone = 1'b0;
    logic [15:0] measDist = 16'h0123;
    logic [15:0] measStrength = 16'h0100;
    logic measStart;
    logic [15:0] distOut;
    logic distValid;
    logic restoreDefaults;
    logic [1:0] pend = 2'h0; // Engine latency countdown
    int shots = 0; // measStart pulses seen
    int restores = 0; // restoreDefaults pulses seen
    int badCount = 0;
    int checksDone = 0;
    logic ok;
    logic [7:0] b0;
    logic [7:0] b1;
    int c;

    // Pull-up: either party driving pulls the wire low
    assign sda = ~(hostOe | (dutOe & ~sdaOut));
    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    lsc_special_regs #(.TICK_CYCLES(TICKS)) lsc_special_regs_i (
        .core_clk(core_clk), .resetn(resetn), .ce(1'b1),
        .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(dutOe),
        .measDone(measDone), .measDist(measDist),
        .measStrength(measStrength), .measStart(measStart),
        .distOut(distOut), .distValid(distValid),
        .restoreDefaults(restoreDefaults));

    lsc_host_model lsc_host_model_i (
        .core_clk(core_clk), .sdaIn(sda), .scl(scl), .sdaOe(hostOe));

    // Engine stand-in: answers each start, counts pulses
    always @(negedge core_clk)
    begin
        measDone <= (pend == 2'h1);
        if (measStart)
            pend <= 2'h3;
        else if (pend != 2'h0)
            pend <= pend - 2'h1;
        if (measStart)
            shots <= shots + 1;
        if (restoreDefaults)
            restores <= restores + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and count; prints only mismatches
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            badCount++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // The single place the run ends
    task automatic printVerdict();
        if (badCount == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : printVerdict

    // Bounded wait for a result pulse
    task automatic waitValid();
        for (int i = 0; i < 100 && distValid !== 1'b1; i++)
            @(negedge core_clk);
        check(16'(distValid), 16'h0001);
        @(negedge core_clk);
    endtask : waitValid

    // Count start pulses over ten timer periods
    task automatic countShots(input logic [15:0] exp);
        c = shots;
        lsc_host_model_i.tick(10 * TICKS);
        check(16'(shots - c), exp);
    endtask : countShots

    ////////////////////////////////////////////////////////////////////////
    task automatic testDefaults();
        lsc_host_model_i.regRead(7'h10, `LSC_REG_ADDR_SET, b0, b1, ok);
        check(16'(ok), 16'h0001);
        check(16'(b0), 16'h0010);
        check(16'(b1), 16'h0000);
        countShots(16'h000A);
    endtask : testDefaults

    // Weak signal at the threshold boundary, then burst readback
    task automatic testWeak();
        measStrength = 16'h0013;
        waitValid();
        waitValid();
        check(distOut, 16'hFFFF);
        measStrength = 16'h0014;
        waitValid();
        waitValid();
        check(distOut, 16'h0123);
        lsc_host_model_i.regRead(7'h10, `LSC_REG_DIST_LO, b0, b1, ok);
        check({b1, b0}, 16'h0123);
    endtask : testWeak

    // Illegal address ignored, burst to mode; nothing changes until reset
    task automatic testConfig();
        lsc_host_model_i.regWrite(7'h10, `LSC_REG_ADDR_SET, 8'h79, 8'h01,
            2, ok);
        lsc_host_model_i.regRead(7'h10, `LSC_REG_ADDR_SET, b0, b1, ok);
        check(16'(b0), 16'h0010);
        check(16'(b1), 16'h0001);
        lsc_host_model_i.regWrite(7'h10, `LSC_REG_ADDR_SET, 8'h78, 8'h02,
            2, ok);
        countShots(16'h000A);
        lsc_host_model_i.regRead(7'h10, `LSC_REG_ADDR_SET, b0, b1, ok);
        check(16'(ok), 16'h0001);
        check(16'(b0), 16'h0078);
        check(16'(b1), 16'h0001);
    endtask : testConfig

    // Reset sequence moves the device to 0x78 in external mode
    task automatic testReset();
        lsc_host_model_i.resetSeq(7'h10);
        lsc_host_model_i.regRead(7'h10, `LSC_REG_ADDR_SET, b0, b1, ok);
        check(16'(ok), 16'h0000);
        lsc_host_model_i.regRead(7'h78, `LSC_REG_ADDR_SET, b0, b1, ok);
        check(16'(ok), 16'h0001);
        countShots(16'h0000);
        c = shots;
        for (int i = 0; i < 2; i++)
        begin
            lsc_host_model_i.regWrite(7'h78, `LSC_REG_SHOT, 8'h01, 8'h00,
                1, ok);
            lsc_host_model_i.tick(2 * TICKS);
        end
        check(16'(shots - c), 16'h0002);
    endtask : testReset

    // Restore key pulses once; address and mode survive
    task automatic testRestore();
        c = restores;
        lsc_host_model_i.regWrite(7'h78, `LSC_REG_RESTORE, 8'h02, 8'h00,
            1, ok);
        lsc_host_model_i.tick(4);
        check(16'(restores - c), 16'h0001);
        lsc_host_model_i.regRead(7'h78, `LSC_REG_ADDR_SET, b0, b1, ok);
        check({b1, b0}, 16'h0178);
    endtask : testRestore

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset held 12 cycles, released on a falling edge
    initial
    begin
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        lsc_host_model_i.tick(4);
        testDefaults();
        testWeak();
        testConfig();
        testReset();
        testRestore();
        printVerdict();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge core_clk);
        badCount++;
        printVerdict();
    end
endmodule : test_lidar_special_config_regs
